/* pkg/tcc8_pkg.sv */
`default_nettype none
package tcc8_pkg;
	localparam int         TCC8_ADDR_W       = 8;
	localparam int         TCC8_DATA_W       = 32;
	localparam int         TCC8_CNT_W        = 8;
	localparam int         TCC8_PRESC_W      = 10;
	localparam int         TCC8_NUM_CH       = 2;
	localparam int         TCC8_NUM_IRQ      = 3;

	localparam logic [7:0] TCC8_OFS_CTRL_A   = 8'h00;
	localparam logic [7:0] TCC8_OFS_CTRL_B   = 8'h04;
	localparam logic [7:0] TCC8_OFS_COUNT    = 8'h08;
	localparam logic [7:0] TCC8_OFS_CMP_A    = 8'h0C;
	localparam logic [7:0] TCC8_OFS_CMP_B    = 8'h10;
	localparam logic [7:0] TCC8_OFS_MASK     = 8'h14;
	localparam logic [7:0] TCC8_OFS_FLAG     = 8'h18;

	localparam int         TCC8_WM_LO_LSB    = 0;
	localparam int         TCC8_ACT_B_LSB    = 4;
	localparam int         TCC8_ACT_A_LSB    = 6;
	localparam int         TCC8_CS_LSB       = 0;
	localparam int         TCC8_WM2_POS      = 3;
	localparam logic [7:0] TCC8_CTRL_A_MASK  = 8'hF3;
	localparam logic [7:0] TCC8_CTRL_B_MASK  = 8'h0F;

	localparam int         TCC8_IRQ_OVF      = 0;
	localparam int         TCC8_IRQ_MATCH0   = 1;

	localparam logic [7:0] TCC8_BOTTOM       = 8'h00;
	localparam logic [7:0] TCC8_MAX          = 8'hFF;
	localparam logic [7:0] TCC8_RST_BYTE     = 8'h00;
	localparam logic [2:0] TCC8_RST_FLAGS    = 3'h0;

	localparam logic [2:0] TCC8_CS_STOP      = 3'h0;
	localparam logic [2:0] TCC8_CS_DIV1      = 3'h1;
	localparam logic [2:0] TCC8_CS_DIV8      = 3'h2;
	localparam logic [2:0] TCC8_CS_DIV64     = 3'h3;
	localparam logic [2:0] TCC8_CS_DIV256    = 3'h4;
	localparam logic [2:0] TCC8_CS_DIV1024   = 3'h5;
	localparam logic [2:0] TCC8_CS_EXT_FALL  = 3'h6;
	localparam logic [2:0] TCC8_CS_EXT_RISE  = 3'h7;

	localparam logic [2:0] TCC8_WM_NORMAL    = 3'h0;
	localparam logic [2:0] TCC8_WM_CTC       = 3'h2;

	localparam logic [1:0] TCC8_ACT_NONE     = 2'h0;
	localparam logic [1:0] TCC8_ACT_TOGGLE   = 2'h1;
endpackage
`default_nettype wire

/* rtl/tcc8_core.sv */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - counter and two compares are 8-bit
// - flags visible, each gated by mask bit
// - tick from prescaler or external pin edge
// - clock select zero stops the counter
// - bottom is 0x00, max is 0xFF
// - top is 0xFF or compare A
// - each tick clears, increments or decrements
// - cpu reads and writes counter anytime
// - cpu counter write beats count or clear
// - wave mode split over two control registers
// - overflow flag set per wave mode
// - comparators flag equality on each channel
// - match flag set on following tick
// - servicing interrupt clears its flag
// - writing one clears flag, zero ignored
// - match and top drive wave outputs
// - compares double buffered only in pwm modes
// - buffer loads active compare at top
// - cpu reaches buffer or active compare
// - three interrupt sources: overflow, A, B
// - clear control zeroes all counter bits
// - normal mode wraps, overflow on zero
// - ctc mode clears on compare A
// - counter write blocks next tick match
module tcc8_core
	import tcc8_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [TCC8_ADDR_W-1:0]  paddr,
	input  wire logic [TCC8_DATA_W-1:0]  pwdata,
	input  wire logic [3:0]              pstrb,
	output logic                         pready,
	output logic [TCC8_DATA_W-1:0]       prdata,
	output logic                         pslverr,
	input  wire logic                    ext_count_input,
	input  wire logic [TCC8_NUM_IRQ-1:0] irq_ack,
	output logic [TCC8_NUM_IRQ-1:0]      irq_req,
	output logic                         wave_out_a,
	output logic                         wave_out_b
);

	logic [7:0]              timer_ctrl_a_reg;
	logic [7:0]              timer_ctrl_b_reg;
	logic [TCC8_CNT_W-1:0]   count_value;
	logic [TCC8_CNT_W-1:0]   next_count;
	logic                    count_down;
	logic                    next_down;
	logic [TCC8_CNT_W-1:0]   cmp_buf [TCC8_NUM_CH];
	logic [TCC8_CNT_W-1:0]   cmp_value [TCC8_NUM_CH];
	logic [TCC8_NUM_IRQ-1:0] timer_flag_reg;
	logic [TCC8_NUM_IRQ-1:0] timer_mask_reg;
	logic [TCC8_NUM_IRQ-1:0] flag_set;
	logic [TCC8_NUM_IRQ-1:0] flag_clr;
	logic [TCC8_NUM_CH-1:0]  match_eq;
	logic [TCC8_NUM_CH-1:0]  wave_q;
	logic [1:0]              output_action_field [TCC8_NUM_CH];
	logic [TCC8_PRESC_W-1:0] presc;
	logic                    ext_s1;
	logic                    ext_s2;
	logic                    ext_s3;
	logic                    timer_tick;
	logic                    match_block;
	logic [2:0]              clock_select_field;
	logic [2:0]              wave_mode_field;
	logic                    pwm;
	logic                    phase;
	logic                    fast;
	logic                    top_is_a;
	logic [TCC8_CNT_W-1:0]   top_val;
	logic                    at_top;
	logic                    at_bottom;
	logic                    ovf_set;
	logic                    setup;
	logic                    access;
	logic                    hit;
	logic                    wr_ok;
	logic                    count_wr;
	logic [7:0]              wdat;
	logic [7:0]              rd_byte;

	function automatic logic addr_is(input logic [TCC8_ADDR_W-1:0] a, input logic [7:0] ofs);
		addr_is = (a == ofs);
	endfunction

	// apb: registered answer, one wait-free access after each setup
	assign setup    = psel & ~penable;
	assign access   = psel & penable & pready;
	assign wdat     = pwdata[7:0];
	assign wr_ok    = access & pwrite & ~pslverr & pstrb[0];
	assign count_wr = wr_ok & addr_is(paddr, TCC8_OFS_COUNT);

	// two control registers together hold the 3-bit wave mode
	assign wave_mode_field    = {timer_ctrl_b_reg[TCC8_WM2_POS],
		timer_ctrl_a_reg[TCC8_WM_LO_LSB +: 2]};
	assign clock_select_field = timer_ctrl_b_reg[TCC8_CS_LSB +: 3];
	assign output_action_field[0] = timer_ctrl_a_reg[TCC8_ACT_A_LSB +: 2];
	assign output_action_field[1] = timer_ctrl_a_reg[TCC8_ACT_B_LSB +: 2];

	// odd modes are the pwm ones; modes 4 and 6 fall back to normal counting
	assign pwm      = wave_mode_field[0];
	assign phase    = pwm & ~wave_mode_field[1];
	assign fast     = pwm & wave_mode_field[1];
	assign top_is_a = (wave_mode_field == TCC8_WM_CTC) | (pwm & wave_mode_field[2]);
	assign top_val  = top_is_a ? cmp_value[0] : TCC8_MAX;
	assign at_top    = (count_value == top_val);
	assign at_bottom = (count_value == TCC8_BOTTOM);

	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			TCC8_OFS_CTRL_A: rd_byte = timer_ctrl_a_reg;
			TCC8_OFS_CTRL_B: rd_byte = timer_ctrl_b_reg;
			TCC8_OFS_COUNT:  rd_byte = count_value;
			TCC8_OFS_CMP_A:  rd_byte = pwm ? cmp_buf[0] : cmp_value[0];
			TCC8_OFS_CMP_B:  rd_byte = pwm ? cmp_buf[1] : cmp_value[1];
			TCC8_OFS_MASK:   rd_byte = {5'h00, timer_mask_reg};
			TCC8_OFS_FLAG:   rd_byte = {5'h00, timer_flag_reg};
			default: begin
				rd_byte = 8'h00;
				hit     = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= {24'h00_0000, rd_byte};
				pslverr <= ~hit;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_ctrl_a_reg <= TCC8_RST_BYTE;
			timer_ctrl_b_reg <= TCC8_RST_BYTE;
			timer_mask_reg   <= TCC8_RST_FLAGS;
		end else if (wr_ok) begin
			if (addr_is(paddr, TCC8_OFS_CTRL_A))
				timer_ctrl_a_reg <= wdat & TCC8_CTRL_A_MASK;
			if (addr_is(paddr, TCC8_OFS_CTRL_B))
				timer_ctrl_b_reg <= wdat & TCC8_CTRL_B_MASK;
			if (addr_is(paddr, TCC8_OFS_MASK))
				timer_mask_reg <= wdat[TCC8_NUM_IRQ-1:0];
		end
	end

	// tick source; the prescaler runs free so a divider change takes effect at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			presc <= '0;
		else
			presc <= presc + 1'b1;
	end

	// ext_s1 is read by ext_s2 only; edges come from ext_s2 against ext_s3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			ext_s1 <= ext_count_input;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	always_comb begin
		unique case (clock_select_field)
			TCC8_CS_STOP:     timer_tick = 1'b0;
			TCC8_CS_DIV1:     timer_tick = 1'b1;
			TCC8_CS_DIV8:     timer_tick = &presc[2:0];
			TCC8_CS_DIV64:    timer_tick = &presc[5:0];
			TCC8_CS_DIV256:   timer_tick = &presc[7:0];
			TCC8_CS_DIV1024:  timer_tick = &presc[9:0];
			TCC8_CS_EXT_FALL: timer_tick = ~ext_s2 & ext_s3;
			TCC8_CS_EXT_RISE: timer_tick = ext_s2 & ~ext_s3;
		endcase
	end

	// counter unit
	always_comb begin
		next_count = count_value;
		next_down  = count_down;
		if (count_wr) begin
			next_count = wdat;
		end else if (timer_tick) begin
			if (phase) begin
				if (count_down && at_bottom) begin
					next_count = count_value + 1'b1;
					next_down  = 1'b0;
				end else if (!count_down && at_top) begin
					next_count = count_value - 1'b1;
					next_down  = 1'b1;
				end else if (count_down) begin
					next_count = count_value - 1'b1;
				end else begin
					next_count = count_value + 1'b1;
				end
			end else if (top_is_a | fast) begin
				next_count = at_top ? TCC8_BOTTOM : count_value + 1'b1;
			end else begin
				next_count = count_value + 1'b1;
			end
			if (!phase)
				next_down = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= TCC8_RST_BYTE;
			count_down  <= 1'b0;
		end else begin
			count_value <= next_count;
			count_down  <= next_down;
		end
	end

	// a counter write lets one tick pass without a match, even when stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			match_block <= 1'b0;
		else if (count_wr)
			match_block <= 1'b1;
		else if (timer_tick)
			match_block <= 1'b0;
	end

	assign ovf_set = timer_tick & ~count_wr & ((~pwm & (count_value == TCC8_MAX)) | (fast & at_top)
		| (phase & count_down & at_bottom));

	// compare channels
	genvar ch;
	generate
		for (ch = 0; ch < TCC8_NUM_CH; ch++) begin : g_ch
			logic cmp_wr;
			logic [1:0] act;
			assign cmp_wr = wr_ok & addr_is(paddr, ch == 0 ? TCC8_OFS_CMP_A : TCC8_OFS_CMP_B);
			assign act    = output_action_field[ch];
			assign match_eq[ch] = (count_value == cmp_value[ch]);
			assign flag_set[TCC8_IRQ_MATCH0 + ch] = timer_tick & match_eq[ch] & ~match_block
				& ~count_wr;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					cmp_buf[ch] <= TCC8_RST_BYTE;
				else if (cmp_wr)
					cmp_buf[ch] <= wdat;
			end

			// direct access outside pwm keeps buffer and active copy equal
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					cmp_value[ch] <= TCC8_RST_BYTE;
				else if (!pwm && cmp_wr)
					cmp_value[ch] <= wdat;
				else if (pwm && timer_tick && at_top && !count_wr)
					cmp_value[ch] <= cmp_buf[ch];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					wave_q[ch] <= 1'b0;
				else if (flag_set[TCC8_IRQ_MATCH0 + ch] && act != TCC8_ACT_NONE) begin
					if (!pwm)
						wave_q[ch] <= (act == TCC8_ACT_TOGGLE) ? ~wave_q[ch] : act[0];
					else if (act[1])
						wave_q[ch] <= act[0] ^ (phase & count_down);
				end else if (fast && act[1] && timer_tick && at_top && !count_wr)
					wave_q[ch] <= ~act[0];
			end
		end
	endgenerate

	assign wave_out_a = wave_q[0];
	assign wave_out_b = wave_q[1];

	// flags: a set in the same cycle as a clear wins
	assign flag_set[TCC8_IRQ_OVF] = ovf_set;
	assign flag_clr = irq_ack | ((wr_ok && addr_is(paddr, TCC8_OFS_FLAG)) ? wdat[2:0] : 3'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_flag_reg <= TCC8_RST_FLAGS;
			irq_req        <= TCC8_RST_FLAGS;
		end else begin
			timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
			irq_req        <= timer_flag_reg & timer_mask_reg & ~flag_clr;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_stop_holds: assert property (clock_select_field == TCC8_CS_STOP && !count_wr |=>
		count_value == $past(count_value)) else $error("counter moved while stopped");
	a_write_wins: assert property (count_wr |=> count_value == $past(wdat))
		else $error("counter write lost");
	a_normal_ovf: assert property (timer_tick && !count_wr && wave_mode_field == TCC8_WM_NORMAL
		&& count_value == TCC8_MAX |=> count_value == TCC8_BOTTOM && timer_flag_reg[TCC8_IRQ_OVF])
		else $error("normal wrap without overflow");
	a_ctc_clear: assert property (timer_tick && !count_wr && wave_mode_field == TCC8_WM_CTC
		&& match_eq[0] |=> count_value == TCC8_BOTTOM) else $error("ctc did not clear");
	a_match_sets: assert property (timer_tick && !count_wr && !match_block && match_eq[0] |=>
		timer_flag_reg[TCC8_IRQ_MATCH0]) else $error("match flag not set");
	a_match_block: assert property (count_wr && !timer_flag_reg[TCC8_IRQ_MATCH0]
		&& !timer_tick ##1 timer_tick && !timer_flag_reg[TCC8_IRQ_MATCH0] |=>
		!timer_flag_reg[TCC8_IRQ_MATCH0]) else $error("match after counter write");
	a_flag_w1c: assert property (wr_ok && addr_is(paddr, TCC8_OFS_FLAG) && wdat[1]
		&& !flag_set[TCC8_IRQ_MATCH0] |=> !timer_flag_reg[TCC8_IRQ_MATCH0])
		else $error("write one did not clear flag");
	a_flag_w0: assert property (wr_ok && addr_is(paddr, TCC8_OFS_FLAG) && !wdat[0] && !irq_ack[0]
		&& timer_flag_reg[TCC8_IRQ_OVF] |=> timer_flag_reg[TCC8_IRQ_OVF])
		else $error("write zero cleared flag");
	a_irq_gate: assert property (timer_flag_reg[TCC8_IRQ_MATCH0] && timer_mask_reg[TCC8_IRQ_MATCH0]
		&& !flag_clr[TCC8_IRQ_MATCH0] ##1 !flag_clr[TCC8_IRQ_MATCH0] |=> irq_req[TCC8_IRQ_MATCH0])
		else $error("masked-in flag gave no request");
	a_irq_mask: assert property (!timer_mask_reg[TCC8_IRQ_OVF] |=> !irq_req[TCC8_IRQ_OVF])
		else $error("masked request raised");
	a_direct_cmp: assert property (!pwm && wr_ok && addr_is(paddr, TCC8_OFS_CMP_A) |=>
		cmp_value[0] == $past(wdat)) else $error("direct compare write lost");
	a_buffer_hold: assert property (pwm && !(timer_tick && at_top) ##1 pwm |->
		cmp_value[1] == $past(cmp_value[1])) else $error("active compare changed off top");
	a_ack_clear: assert property (irq_ack[TCC8_IRQ_OVF] && !ovf_set |=> !timer_flag_reg[TCC8_IRQ_OVF])
		else $error("service did not clear flag");
	a_apb_answer: assert property (setup |=> pready ##1 !pready || setup)
		else $error("apb answer timing");

	c_overflow: cover property (ovf_set ##1 irq_req[TCC8_IRQ_OVF]);
	c_match_b: cover property (flag_set[TCC8_IRQ_MATCH0 + 1]);
	c_phase_turn: cover property (phase && count_down ##1 !count_down);
	c_ctc_wrap: cover property (wave_mode_field == TCC8_WM_CTC && timer_tick && match_eq[0]);

endmodule
`default_nettype wire

/* test/timer8_counter_compare_core_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module timer8_counter_compare_core_bench;
	import tcc8_pkg::*;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] x;
		logic        e;
	} tcc8_row_s;
	logic                    pclk;
	logic                    presetn;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [TCC8_ADDR_W-1:0]  paddr;
	logic [TCC8_DATA_W-1:0]  pwdata;
	logic [3:0]              pstrb;
	logic                    pready;
	logic [TCC8_DATA_W-1:0]  prdata;
	logic                    pslverr;
	logic                    ext_count_input;
	logic [TCC8_NUM_IRQ-1:0] irq_ack;
	logic [TCC8_NUM_IRQ-1:0] irq_req;
	logic                    wave_out_a;
	logic                    wave_out_b;
	logic [31:0]             rd;
	logic                    er;
	int                      errors;
	int                      num_checks;
	tcc8_row_s               rows [$];

	tcc8_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ext_count_input(ext_count_input), .irq_ack(irq_ack), .irq_req(irq_req),
		.wave_out_a(wave_out_a), .wave_out_b(wave_out_b));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// the slave sets its own pace; only the watchdog ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h0, d}, 4'hF);
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] x);
		apb(a, 1'b0, 32'h0, 4'hF);
		chk(n, rd, {24'h0, x});
	endtask

	task automatic pin_pulse();
		repeat (2) begin
			@(posedge pclk);
			ext_count_input <= ~ext_count_input;
			repeat (8) @(posedge pclk);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		summarize();
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; pstrb = 4'hF; ext_count_input = 1'b0; irq_ack = 3'h0;
		errors = 0; num_checks = 0;
		rows = '{
			'{8'h00, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0},
			'{8'h08, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0}, '{8'h0C, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0},
			'{8'h10, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0}, '{8'h14, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0},
			'{8'h18, 1'b0, 32'h0, 4'hF, 32'h0, 1'b0},
			'{8'h00, 1'b1, 32'hFF, 4'hF, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 4'hF, 32'hF3, 1'b0},
			'{8'h00, 1'b1, 32'h00, 4'hF, 32'h0, 1'b0},
			'{8'h04, 1'b1, 32'hF8, 4'hF, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h0, 4'hF, 32'h08, 1'b0},
			'{8'h04, 1'b1, 32'h00, 4'hF, 32'h0, 1'b0},
			'{8'h08, 1'b1, 32'hA5, 4'hF, 32'h0, 1'b0}, '{8'h08, 1'b0, 32'h0, 4'hF, 32'hA5, 1'b0},
			'{8'h08, 1'b1, 32'h5A, 4'hE, 32'h0, 1'b0}, '{8'h08, 1'b0, 32'h0, 4'hF, 32'hA5, 1'b0},
			'{8'h0C, 1'b1, 32'h3C, 4'hF, 32'h0, 1'b0}, '{8'h0C, 1'b0, 32'h0, 4'hF, 32'h3C, 1'b0},
			'{8'h10, 1'b1, 32'hC3, 4'hF, 32'h0, 1'b0}, '{8'h10, 1'b0, 32'h0, 4'hF, 32'hC3, 1'b0},
			'{8'h14, 1'b1, 32'hFF, 4'hF, 32'h0, 1'b0}, '{8'h14, 1'b0, 32'h0, 4'hF, 32'h07, 1'b0},
			'{8'h1C, 1'b1, 32'h11, 4'hF, 32'h0, 1'b1}, '{8'h1C, 1'b0, 32'h0, 4'hF, 32'h0, 1'b1}
		};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d, rows[i].s);
			chk("pslverr", {31'h0, er}, {31'h0, rows[i].e});
			if (!rows[i].w)
				chk("prdata", rd, rows[i].x);
		end
		// clear on match with top 3, flag A only, masked through
		wr(8'h00, 8'h02);
		wr(8'h0C, 8'h03);
		wr(8'h08, 8'h00);
		wr(8'h14, 8'h02);
		wr(8'h18, 8'h07);
		wr(8'h04, 8'h01);
		repeat (40) @(posedge pclk);
		wr(8'h04, 8'h00);
		apb(8'h08, 1'b0, 32'h0, 4'hF);
		chk("count_le_top", {31'h0, rd[7:0] <= 8'h03}, 32'h1);
		rdc("flags_ctc", 8'h18, 8'h02);
		chk("irq_ctc", {29'h0, irq_req}, 32'h2);
		wr(8'h18, 8'h05);
		rdc("flags_w0", 8'h18, 8'h02);
		wr(8'h18, 8'h02);
		rdc("flags_w1c", 8'h18, 8'h00);
		chk("irq_clr", {29'h0, irq_req}, 32'h0);
		// stopped timer keeps a written value
		wr(8'h08, 8'h33);
		repeat (10) @(posedge pclk);
		rdc("count_stop", 8'h08, 8'h33);
		// count written equal to compare B: the match right after is blocked
		wr(8'h00, 8'h00);
		wr(8'h0C, 8'h80);
		wr(8'h10, 8'h20);
		wr(8'h08, 8'h20);
		wr(8'h14, 8'h01);
		wr(8'h04, 8'h01);
		repeat (3) @(posedge pclk);
		wr(8'h04, 8'h00);
		rdc("flags_block", 8'h18, 8'h00);
		wr(8'h08, 8'hFE);
		wr(8'h04, 8'h01);
		repeat (5) @(posedge pclk);
		wr(8'h04, 8'h00);
		rdc("flags_ovf", 8'h18, 8'h01);
		chk("irq_ovf", {29'h0, irq_req}, 32'h1);
		@(posedge pclk);
		irq_ack <= 3'h1;
		@(posedge pclk);
		irq_ack <= 3'h0;
		rdc("flags_ack", 8'h18, 8'h00);
		// external pin: four rising then three falling edges
		wr(8'h08, 8'h00);
		wr(8'h04, 8'h07);
		repeat (4) pin_pulse();
		wr(8'h04, 8'h06);
		repeat (3) pin_pulse();
		wr(8'h04, 8'h00);
		rdc("count_ext", 8'h08, 8'h07);
		// phase pwm: compare B write lands in the buffer, active copy keeps its old value
		wr(8'h00, 8'h01);
		wr(8'h10, 8'h10);
		rdc("cmpb_buf", 8'h10, 8'h10);
		wr(8'h00, 8'h00);
		rdc("cmpb_act", 8'h10, 8'h20);
		// normal mode, action A sets the output on match, B has no action
		wr(8'h00, 8'hC0);
		wr(8'h0C, 8'h02);
		wr(8'h08, 8'h00);
		wr(8'h04, 8'h01);
		repeat (10) @(posedge pclk);
		wr(8'h04, 8'h00);
		chk("wave_a_set", {31'h0, wave_out_a}, 32'h1);
		chk("wave_b_idle", {31'h0, wave_out_b}, 32'h0);
		// reset in mid-run brings everything back to zero
		wr(8'h04, 8'h01);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl_b_rst", 8'h04, 8'h00);
		rdc("count_rst", 8'h08, 8'h00);
		rdc("flags_rst", 8'h18, 8'h00);
		chk("wave_a_rst", {31'h0, wave_out_a}, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
